// ==== common/lcdsp_pkg.sv ====
// Package: register map, field layout and timing constants of the LCD drive block
package lcdsp_pkg;

	// ----------------------------------------------------------------
	// Register word indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL   = 6'h00;
	localparam logic [5:0] IDX_PHASE  = 6'h01;
	localparam logic [5:0] IDX_REF    = 6'h02;
	localparam logic [5:0] IDX_LADDER = 6'h03;
	localparam logic [5:0] IDX_SEG    = 6'h04;
	localparam logic [5:0] IDX_PIX    = 6'h10;
	localparam logic [5:0] NUM_SEG    = 6'h06;
	localparam logic [5:0] NUM_PIX    = 6'h18;

	// ----------------------------------------------------------------
	// Field positions, write masks and reset value
	// ----------------------------------------------------------------
	localparam int CTRL_EN   = 7;
	localparam int CTRL_CS   = 2;
	localparam int PH_BIAS   = 6;
	localparam int PH_ACT    = 5;
	localparam int REF_IRE   = 7;
	localparam int REF_IRS   = 6;
	localparam int REF_CST   = 3;
	localparam int LAD_AP    = 6;
	localparam int LAD_BP    = 4;
	localparam logic [7:0] CTRL_WMASK = 8'h8F;
	localparam logic [7:0] LAD_WMASK  = 8'hF7;
	localparam logic [7:0] REG_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// Reduced-pin variant and clock dividers
	// ----------------------------------------------------------------
	localparam int GRP_PARTIAL = 4;
	localparam int GRP_ABSENT  = 5;
	localparam logic [7:0] PARTIAL_MASK = 8'h01;
	localparam int SYS_PREDIV  = 4;
	localparam int SYS_FIXDIV  = 8192;
	localparam int OSC_DIV     = 32;
	localparam int SEG_COUNTS  = 32;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CS_SYS = 2'b00, CS_SECONDARY_OSCILLATOR = 2'b01, CS_RC = 2'b10, CS_RC2 = 2'b11
	} lcdsp_cs_e;
	typedef enum logic [1:0] {
		PWR_OFF = 2'b00, PWR_LOW = 2'b01, PWR_MED = 2'b10, PWR_HIGH = 2'b11
	} lcdsp_pwr_e;
	typedef enum logic [1:0] {
		BIAS_STATIC = 2'b00, BIAS_HALF = 2'b01, BIAS_THIRD = 2'b10
	} lcdsp_bias_e;
	typedef enum logic {IVAL_A = 1'b0, IVAL_B = 1'b1} lcdsp_ival_e;

	// Ladder enables driven toward the analog bias network
	typedef struct packed {
		logic low_on;
		logic med_on;
		logic high_on;
		logic contrast_on;
	} lcdsp_ladder_s;

endpackage

// ==== rtl/lcdsp_clkgen.sv ====
// LCD clock source selection, fixed dividers and power-of-two prescaler
`timescale 1ns/1ps
module lcdsp_clkgen #(
	parameter int SYS_DIV_CYC = lcdsp_pkg::SYS_PREDIV * lcdsp_pkg::SYS_FIXDIV
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       secondary_oscillator_clk_i,
	input  wire logic       internal_rc_osc_clk_i,
	input  wire logic [1:0] src_sel,
	input  wire logic [3:0] prescale_sel,
	input  wire logic       restart,
	input  wire logic       run,
	output logic            lcd_tick
);
	import lcdsp_pkg::*;

	logic [2:0]  so_s, rc_s;
	logic        so_l, rc_l, so_e, rc_e;
	logic [15:0] sys_q, pre_q;
	logic [4:0]  so_q, rc_q;
	wire         sys_t = (sys_q == 16'(SYS_DIV_CYC - 1));
	wire         so_t  = so_e && (so_q == 5'(OSC_DIV - 1));
	wire         rc_t  = rc_e && (rc_q == 5'(OSC_DIV - 1));
	// Source encoding: 00 system, 01 secondary osc, 1x internal RC
	wire         src_t = (src_sel == CS_SYS) ? sys_t : (src_sel == CS_SECONDARY_OSCILLATOR) ? so_t : rc_t;
	wire [15:0]  pre_lim = 16'((17'h00001 << prescale_sel) - 17'h00001);

	// Pin clocks: a rising edge counts once stages two and three agree
	always_ff @(posedge aclk) begin
		so_s <= {so_s[1:0], secondary_oscillator_clk_i};
		rc_s <= {rc_s[1:0], internal_rc_osc_clk_i};
		so_l <= (so_s[1] == so_s[2]) ? so_s[2] : so_l;
		rc_l <= (rc_s[1] == rc_s[2]) ? rc_s[2] : rc_l;
	end
	assign so_e = (so_s[1] == so_s[2]) && so_s[2] && !so_l;
	assign rc_e = (rc_s[1] == rc_s[2]) && rc_s[2] && !rc_l;

	// Fixed dividers; the system path ratio is not programmable
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_t) sys_q <= 16'h0000;
		else sys_q <= sys_q + 16'h0001;
		if (!aresetn || so_t) so_q <= 5'h00;
		else so_q <= so_q + 5'(so_e);
		if (!aresetn || rc_t) rc_q <= 5'h00;
		else rc_q <= rc_q + 5'(rc_e);
	end

	// Hidden 16-bit prescaler; a new ratio restarts the count
	always_ff @(posedge aclk) begin
		if (!aresetn || restart || !run) pre_q <= 16'h0000;
		else if (src_t) pre_q <= (pre_q >= pre_lim) ? 16'h0000 : pre_q + 16'h0001;
	end
	assign lcd_tick = run && src_t && (pre_q >= pre_lim);

	a_pre_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		restart |=> pre_q == 16'h0000) else $error("prescaler not restarted");
	a_sys_div: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sys_t) |-> $past(sys_q) == 16'(SYS_DIV_CYC - 2)) else $error("system divider ratio");
endmodule

// ==== rtl/lcdsp_ladder.sv ====
// Segment-time counter and interval A/B reference ladder power control
`timescale 1ns/1ps
module lcdsp_ladder (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                lcd_tick,
	input  wire logic                active,
	input  wire logic                ref_en,
	input  wire logic [7:0]          ladder_cfg,
	output lcdsp_pkg::lcdsp_ladder_s ladder_o
);
	import lcdsp_pkg::*;

	logic [4:0]  cnt_q;
	lcdsp_ival_e ival_q;
	wire  [4:0]  cnt_n = (cnt_q == 5'(SEG_COUNTS - 1)) ? 5'h00 : cnt_q + 5'h01;
	wire  [4:0]  a_len = {2'b00, ladder_cfg[2:0]};
	wire  [1:0]  pwr   = (ival_q == IVAL_A) ? ladder_cfg[LAD_AP +: 2] : ladder_cfg[LAD_BP +: 2];
	wire         on    = active && ref_en;

	// Count zero is the waveform transition; A runs first, B fills the rest
	always_ff @(posedge aclk) begin
		if (!aresetn || !active) begin
			cnt_q  <= 5'h00;
			ival_q <= IVAL_B;
		end else if (lcd_tick) begin
			cnt_q  <= cnt_n;
			ival_q <= (cnt_n < a_len) ? IVAL_A : IVAL_B;
		end
	end

	// High power in interval A also switches in the medium ladder
	assign ladder_o.low_on  = on && (pwr == PWR_LOW);
	assign ladder_o.med_on  = on && ((pwr == PWR_MED) ||
		((pwr == PWR_HIGH) && (ival_q == IVAL_A)));
	assign ladder_o.high_on = on && (pwr == PWR_HIGH);
	assign ladder_o.contrast_on = on;

	sequence s_a_high;
		(ival_q == IVAL_A) && (ladder_cfg[LAD_AP +: 2] == PWR_HIGH) && on;
	endsequence
	a_both_ladders: assert property (@(posedge aclk) disable iff (!aresetn)
		s_a_high |-> ladder_o.med_on && ladder_o.high_on) else $error("high A needs both");
	a_inactive_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!active |-> ladder_o == '0) else $error("ladder on while inactive");
endmodule

// ==== rtl/lcdsp_top.sv ====
// LCD segment/pixel drive control with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lcdsp_top #(
	parameter bit REDUCED     = 1'b0,
	parameter int SYS_DIV_CYC = lcdsp_pkg::SYS_PREDIV * lcdsp_pkg::SYS_FIXDIV
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [7:0]          araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	input  wire logic                sleep_i,
	input  wire logic                secondary_oscillator_clk_i,
	input  wire logic                internal_rc_osc_clk_i,
	output logic [47:0]              seg_drive_en_o,
	output logic [191:0]             pixel_o,
	output logic [3:0]               com_used_o,
	output logic [2:0]               shared_common_pins_o,
	output logic [1:0]               bias_type_o,
	output logic [2:0]               bias_pin_en_o,
	output logic [2:0]               contrast_o,
	output logic                     ref_source_o,
	output logic                     lcd_tick_o,
	output lcdsp_pkg::lcdsp_ladder_s ladder_o
);
	import lcdsp_pkg::*;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_q;
	logic [3:0]  prescale_select_q;
	logic        bias_half_q;
	logic [7:0]  ref_q;
	logic [7:0]  ladder_q;
	logic [7:0]  se_q  [6];
	logic [7:0]  pix_q [24];
	logic        active_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [7:0]  rdata_q;

	// ----------------------------------------------------------------
	// Write channel decode
	// ----------------------------------------------------------------
	// Address and data are taken together, so no skid storage is needed
	wire       wr_go  = awvalid && wvalid && !bvalid_q;
	wire       wr_en  = wr_go && wstrb[0];
	wire [5:0] w_idx  = awaddr[7:2];
	wire [7:0] wd     = wdata[7:0];
	wire [5:0] w_se   = w_idx - IDX_SEG;
	wire [5:0] w_px   = w_idx - IDX_PIX;
	wire       w_is_se = (w_idx >= IDX_SEG) && (w_se < NUM_SEG);
	wire       w_is_px = (w_idx >= IDX_PIX) && (w_px < NUM_PIX);
	wire       w_hit  = (w_idx <= IDX_LADDER) || w_is_se || w_is_px;

	assign awready = wr_go;
	assign wready  = wr_go;

	// ----------------------------------------------------------------
	// Read channel decode
	// ----------------------------------------------------------------
	wire       rd_go   = arvalid && !rvalid_q;
	wire [5:0] r_idx   = araddr[7:2];
	wire [5:0] r_se    = r_idx - IDX_SEG;
	wire [5:0] r_px    = r_idx - IDX_PIX;
	wire       r_is_se = (r_idx >= IDX_SEG) && (r_se < NUM_SEG);
	wire       r_is_px = (r_idx >= IDX_PIX) && (r_px < NUM_PIX);
	wire       r_hit   = (r_idx <= IDX_LADDER) || r_is_se || r_is_px;
	wire [7:0] phase_rd = {1'b0, bias_half_q, active_q, 1'b0, prescale_select_q};
	// The prescaler count itself is never visible here
	wire [7:0] r_byte  =
		(r_idx == IDX_CTRL)   ? ctrl_q :
		(r_idx == IDX_PHASE)  ? phase_rd :
		(r_idx == IDX_REF)    ? ref_q :
		(r_idx == IDX_LADDER) ? ladder_q :
		r_is_se ? se_q[r_se[2:0]] :
		r_is_px ? pix_q[r_px[4:0]] : REG_RESET;

	assign arready = !rvalid_q;

	// ----------------------------------------------------------------
	// Control, phase, reference and ladder registers
	// ----------------------------------------------------------------
	// Reset leaves multiplex select at static
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q            <= REG_RESET;
			prescale_select_q <= REG_RESET[3:0];
			bias_half_q       <= 1'b0;
			ref_q             <= REG_RESET;
			ladder_q          <= REG_RESET;
		end else if (wr_en) begin
			if (w_idx == IDX_CTRL) ctrl_q <= wd & CTRL_WMASK;
			if (w_idx == IDX_PHASE) begin
				prescale_select_q <= wd[3:0];
				bias_half_q       <= wd[PH_BIAS];
			end
			if (w_idx == IDX_REF) ref_q <= wd;
			if (w_idx == IDX_LADDER) ladder_q <= wd & LAD_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Segment enable and pixel registers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_se
			// Absent enables in the reduced variant ignore writes, read zero
			localparam bit PRESENT = !(REDUCED && (g >= GRP_PARTIAL));
			always_ff @(posedge aclk) begin
				if (!aresetn) se_q[g] <= REG_RESET;
				else if (wr_en && w_is_se && (w_se == 6'(g)) && PRESENT) se_q[g] <= wd;
			end
			assign seg_drive_en_o[g*8 +: 8] = se_q[g];
		end
		for (g = 0; g < 24; g++) begin : g_pix
			// Cells always store, so unused pixels serve as general storage
			localparam logic [7:0] MASK =
				!REDUCED ? 8'hFF :
				((g % 6) == GRP_ABSENT) ? 8'h00 :
				((g % 6) == GRP_PARTIAL) ? PARTIAL_MASK : 8'hFF;
			always_ff @(posedge aclk) begin
				if (!aresetn) pix_q[g] <= REG_RESET;
				else if (wr_en && w_is_px && (w_px == 6'(g))) pix_q[g] <= wd;
			end
			// Common g/6, segment group g mod 6; 1 drives the pixel dark
			assign pixel_o[(g/6)*48 + (g%6)*8 +: 8] = pix_q[g] & MASK;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------
	// One-cycle answer; unmapped words give SLVERR and read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= w_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= REG_RESET;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rresp_q  <= r_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= r_byte;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp  = rresp_q;
	assign rdata  = {24'h000000, rdata_q};

	// ----------------------------------------------------------------
	// Module active status
	// ----------------------------------------------------------------
	// The system-derived clock stops in sleep; the oscillators keep running
	wire sys_src  = (ctrl_q[CTRL_CS +: 2] == CS_SYS);
	wire active_d = ctrl_q[CTRL_EN] && !(sleep_i && sys_src);
	always_ff @(posedge aclk) begin
		if (!aresetn) active_q <= 1'b0;
		else active_q <= active_d;
	end

	// ----------------------------------------------------------------
	// Clock generation and ladder power control
	// ----------------------------------------------------------------
	wire ps_wr = wr_en && (w_idx == IDX_PHASE);

	lcdsp_clkgen #(.SYS_DIV_CYC(SYS_DIV_CYC)) u_clkgen (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.secondary_oscillator_clk_i   (secondary_oscillator_clk_i),
		.internal_rc_osc_clk_i  (internal_rc_osc_clk_i),
		.src_sel      (ctrl_q[CTRL_CS +: 2]),
		.prescale_sel (prescale_select_q),
		.restart      (ps_wr),
		.run          (active_q),
		.lcd_tick     (lcd_tick_o)
	);

	lcdsp_ladder u_ladder (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.lcd_tick   (lcd_tick_o),
		.active     (active_q),
		.ref_en     (ref_q[REF_IRE]),
		.ladder_cfg (ladder_q),
		.ladder_o   (ladder_o)
	);

	// ----------------------------------------------------------------
	// Reference, contrast, bias and common pin outputs
	// ----------------------------------------------------------------
	// Contrast taps only mean something with the internal reference on
	assign contrast_o    = ladder_o.contrast_on ? ref_q[REF_CST +: 3] : 3'h0;
	assign ref_source_o  = ref_q[REF_IRS];
	assign bias_pin_en_o = ref_q[2:0];

	// Static mux forces static bias; 1/4 mux forces third bias
	wire [1:0] mux = ctrl_q[1:0];
	assign bias_type_o = (mux == 2'b00) ? BIAS_STATIC :
		((mux != 2'b11) && bias_half_q) ? BIAS_HALF : BIAS_THIRD;

	// Commons in use and shared pins taken over from digital I/O
	assign com_used_o = {mux == 2'b11, mux >= 2'b10, mux >= 2'b01, 1'b1};
	assign shared_common_pins_o = com_used_o[3:1];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_seg_enable_map: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_en && (w_idx == IDX_SEG) |=> seg_drive_en_o[7:0] == $past(wd))
		else $error("segment enable not applied");

	a_pixel_map: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_en && (w_idx == IDX_PIX + 6'h07) |=> pixel_o[63:56] == $past(wd))
		else $error("pixel register 7 must drive common 1, segments 8-15");

	a_reduced_absent: assert property (@(posedge aclk) disable iff (!aresetn)
		REDUCED |-> (seg_drive_en_o[47:32] == 16'h0000) && (pixel_o[47:33] == 15'h0000))
		else $error("absent segments driven");

	a_sleep_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_i && sys_src ##1 sleep_i && sys_src |-> !active_q)
		else $error("system clock source kept running in sleep");

	a_mux_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		(mux == 2'b01) |-> shared_common_pins_o == 3'b001)
		else $error("half mux must take only the common 1 pin");

	a_contrast_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!ref_q[REF_IRE] |-> contrast_o == 3'h0)
		else $error("contrast active without internal reference");

	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go |=> bvalid ##0 (bresp == ($past(w_hit) ? RESP_OKAY : RESP_SLVERR)) [*1])
		else $error("write response missing");

	// Read answer carries the status of the word that was addressed
	a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go |=> rvalid && (rresp == ($past(r_hit) ? RESP_OKAY : RESP_SLVERR)))
		else $error("read response missing");

	// A pending write answer must not move before the master takes it
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");

	// A pending read answer must not move before the master takes it
	a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped");

	// Absent enables of the reduced variant must ignore every write
	a_absent_write: assert property (@(posedge aclk) disable iff (!aresetn)
		REDUCED && wr_en && w_is_se && (w_se >= 6'(GRP_PARTIAL))
		|=> $stable(seg_drive_en_o[47:32]))
		else $error("absent segment enable written");

	// Static multiplex runs static bias, quarter multiplex third bias
	a_bias_static: assert property (@(posedge aclk) disable iff (!aresetn)
		(mux == 2'b00) |-> bias_type_o == BIAS_STATIC)
		else $error("static multiplex needs static bias");
	a_bias_third: assert property (@(posedge aclk) disable iff (!aresetn)
		(mux == 2'b11) |-> bias_type_o == BIAS_THIRD)
		else $error("quarter multiplex needs third bias");

	// Quarter multiplex takes all three shared pins for common drive
	a_mux_quarter: assert property (@(posedge aclk) disable iff (!aresetn)
		(mux == 2'b11) |-> shared_common_pins_o == 3'b111)
		else $error("quarter multiplex must take all shared pins");

	// Static multiplex scans common 0 only
	a_com_static: assert property (@(posedge aclk) disable iff (!aresetn)
		(mux == 2'b00) |-> com_used_o == 4'h1)
		else $error("static multiplex scans extra commons");

	// Contrast taps follow the field whenever the reference ladder is live
	a_contrast_tap: assert property (@(posedge aclk) disable iff (!aresetn)
		ladder_o.contrast_on |-> contrast_o == ref_q[REF_CST +: 3])
		else $error("contrast tap not applied");

	// Sleep on the system-derived source must stop the tick as well
	sequence s_sys_sleep;
		sleep_i && sys_src ##1 sleep_i && sys_src;
	endsequence
	a_sleep_tick: assert property (@(posedge aclk) disable iff (!aresetn)
		s_sys_sleep |-> !lcd_tick_o)
		else $error("tick kept running in sleep");
endmodule

// ==== bench/lcdsp_glass.sv ====
// Behavioural model of the LCD glass: which pixels actually turn dark
`timescale 1ns/1ps
module lcdsp_glass (
	input  wire logic [47:0]  seg_en,
	input  wire logic [191:0] pixel,
	input  wire logic [3:0]   com_used,
	output logic [191:0]      dark
);
	// ----------------------------------------------------------------
	// Pixel view
	// ----------------------------------------------------------------
	// A pixel darkens only on a driven segment of a scanned common
	always_comb begin
		for (int i = 0; i < 192; i++) begin
			dark[i] = pixel[i] & seg_en[i % 48] & com_used[i / 48];
		end
	end
endmodule

// ==== bench/testbench.sv ====
// Self-checking testbench of the LCD segment and pixel drive control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench;
	import lcdsp_pkg::*;
	// Short system divider keeps the tick gaps to a few cycles
	localparam int DIV = 8;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [7:0]    awaddr = 8'h00;
	logic [7:0]    araddr = 8'h00;
	logic [31:0]   wdata = 32'h0;
	logic [3:0]    wstrb = 4'hF;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic          arvalid = 1'b0, rready = 1'b0;
	logic          sleep_i = 1'b0, secondary_oscillator = 1'b0, internal_rc_osc = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid, lcd_tick_o, ref_source_o;
	logic [1:0]    bresp, rresp, bias_type_o;
	logic [31:0]   rdata;
	logic [47:0]   seg_drive_en_o;
	logic [191:0]  pixel_o, dark;
	logic [47:0]   red_seg;
	logic [191:0]  red_pix;
	logic [31:0]   red_rdata;
	logic [3:0]    com_used_o;
	logic [2:0]    shared_common_pins_o, bias_pin_en_o, contrast_o;
	lcdsp_ladder_s ladder_o;
	int            miscompares = 0, num_checks = 0, cycles = 0, osc_cnt = 0;

	lcdsp_top #(.REDUCED(1'b0), .SYS_DIV_CYC(DIV)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sleep_i(sleep_i), .secondary_oscillator_clk_i(secondary_oscillator),
		.internal_rc_osc_clk_i(internal_rc_osc), .seg_drive_en_o(seg_drive_en_o), .pixel_o(pixel_o),
		.com_used_o(com_used_o), .shared_common_pins_o(shared_common_pins_o),
		.bias_type_o(bias_type_o), .bias_pin_en_o(bias_pin_en_o), .contrast_o(contrast_o),
		.ref_source_o(ref_source_o), .lcd_tick_o(lcd_tick_o), .ladder_o(ladder_o));
	lcdsp_glass i_glass (.seg_en(seg_drive_en_o), .pixel(pixel_o), .com_used(com_used_o),
		.dark(dark));
	// Reduced-pin variant runs in lockstep on the same bus; only its outputs are watched
	lcdsp_top #(.REDUCED(1'b1), .SYS_DIV_CYC(DIV)) i_dut_red (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(), .rdata(red_rdata), .rresp(),
		.rvalid(), .rready(rready), .sleep_i(sleep_i), .secondary_oscillator_clk_i(secondary_oscillator),
		.internal_rc_osc_clk_i(internal_rc_osc), .seg_drive_en_o(red_seg), .pixel_o(red_pix),
		.com_used_o(), .shared_common_pins_o(), .bias_type_o(), .bias_pin_en_o(),
		.contrast_o(), .ref_source_o(), .lcd_tick_o(), .ladder_o());

	// ----------------------------------------------------------------
	// Clocks, oscillators and hang guard
	// ----------------------------------------------------------------
	// Oscillators: rising edge every 4 and every 6 system cycles
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		osc_cnt <= osc_cnt + 1;
		if (osc_cnt % 2 == 1) secondary_oscillator <= ~secondary_oscillator;
		if (osc_cnt % 3 == 2) internal_rc_osc <= ~internal_rc_osc;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Bus and timing helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK("rdata", {24'h0, ed}, rdata)
		`CHK("rresp", er, rresp)
	endtask
	// Cycles between two ticks; the first tick after a change may be partial
	task automatic gap(output int n);
		n = 0;
		do @(posedge aclk); while (lcd_tick_o !== 1'b1);
		do begin
			@(posedge aclk);
			n++;
		end while (lcd_tick_o !== 1'b1 && n < 2000);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 10; i++) rd(6'(i), 8'h00, RESP_OKAY);
		`CHK("com_rst", 4'h1, com_used_o)
		`CHK("seg_rst", 48'h0, seg_drive_en_o)
		`CHK("pix_rst", 192'h0, pixel_o)
	endtask
	task automatic t_seg();
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			v = 8'h81 ^ 8'(i * 37);
			wr(6'(4 + i), v, RESP_OKAY);
			`CHK("seg_en", v, seg_drive_en_o[8 * i +: 8])
			`CHK("red_seg", (i < GRP_PARTIAL) ? v : 8'h00, red_seg[8 * i +: 8])
			rd(6'(4 + i), v, RESP_OKAY);
		end
	endtask
	task automatic t_pix();
		logic [7:0] v;
		logic [7:0] rv;
		int b;
		wr(IDX_CTRL, 8'h03, RESP_OKAY);
		for (int i = 0; i < 6; i++) wr(6'(4 + i), 8'hFF, RESP_OKAY);
		for (int x = 0; x < 24; x++) wr(6'(16 + x), 8'h5A ^ 8'(x), RESP_OKAY);
		for (int x = 0; x < 24; x++) begin
			v = 8'h5A ^ 8'(x);
			b = (x / 6) * 48 + 8 * (x % 6);
			`CHK("pixel", v, pixel_o[b +: 8])
			`CHK("dark", v, dark[b +: 8])
			// Reduced variant: group 5 shows nothing, group 4 shows bit 0 only
			rv = ((x % 6) == GRP_ABSENT) ? 8'h00 : ((x % 6) == GRP_PARTIAL) ? (v & 8'h01) : v;
			`CHK("red_pix", rv, red_pix[b +: 8])
		end
		rd(6'h15, 8'h5F, RESP_OKAY);
		`CHK("red_store", {24'h0, 8'h5F}, red_rdata)
		wr(6'h04, 8'h00, RESP_OKAY);
		`CHK("dark_off", 8'h00, dark[7:0])
	endtask
	task automatic t_mux();
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CTRL, 8'(m), RESP_OKAY);
			`CHK("com_used", 4'hF >> (3 - m), com_used_o)
			`CHK("com_pins", 3'h7 >> (3 - m), shared_common_pins_o)
			`CHK("bias", (m == 0) ? 2'h0 : 2'h2, bias_type_o)
		end
		wr(IDX_CTRL, 8'h01, RESP_OKAY);
		wr(IDX_PHASE, 8'h40, RESP_OKAY);
		`CHK("bias_half", 2'h1, bias_type_o)
		wr(IDX_PHASE, 8'h00, RESP_OKAY);
	endtask
	task automatic t_clk();
		int n;
		wr(IDX_CTRL, 8'h80, RESP_OKAY);
		gap(n);
		`CHK("gap_sys", DIV, n)
		wr(IDX_PHASE, 8'h02, RESP_OKAY);
		gap(n);
		`CHK("gap_pre", DIV << 2, n)
		wr(IDX_PHASE, 8'h00, RESP_OKAY);
		sleep_i <= 1'b1;
		cyc(5);
		n = 0;
		repeat (100) begin
			@(posedge aclk);
			n += int'(lcd_tick_o === 1'b1);
		end
		`CHK("sleep_sys", 0, n)
		for (int c = 1; c < 4; c++) begin
			wr(IDX_CTRL, 8'h80 | 8'(c << 2), RESP_OKAY);
			gap(n);
			`CHK("gap_osc", (c == 1) ? 128 : 192, n)
		end
		sleep_i <= 1'b0;
	endtask
	task automatic t_lad();
		int na, nb;
		wr(IDX_CTRL, 8'h80, RESP_OKAY);
		wr(IDX_REF, 8'hEB, RESP_OKAY);
		`CHK("pins", 3'h3, bias_pin_en_o)
		`CHK("contrast", 3'h5, contrast_o)
		`CHK("ref_src", 1'b1, ref_source_o)
		wr(IDX_LADDER, 8'hD0, RESP_OKAY);
		cyc(20);
		`CHK("lad_b", 3'h4, {ladder_o.low_on, ladder_o.med_on, ladder_o.high_on})
		wr(IDX_LADDER, 8'hFF, RESP_OKAY);
		rd(IDX_LADDER, 8'hF7, RESP_OKAY);
		// Let one tick pass so the interval state follows the new length
		cyc(8);
		na = 0;
		nb = 0;
		// One full segment time of 32 ticks, 8 cycles each
		repeat (256) begin
			@(posedge aclk);
			na += int'(ladder_o.med_on === 1'b1 && ladder_o.high_on === 1'b1);
			nb += int'(ladder_o.med_on === 1'b0 && ladder_o.high_on === 1'b1);
		end
		`CHK("lad_a_cnt", 56, na)
		`CHK("lad_b_cnt", 200, nb)
		wr(IDX_REF, 8'h6B, RESP_OKAY);
		`CHK("lad_noref", 4'h0, ladder_o)
		`CHK("cst_noref", 3'h0, contrast_o)
		wr(IDX_REF, 8'hEB, RESP_OKAY);
		wr(IDX_CTRL, 8'h00, RESP_OKAY);
		cyc(2);
		`CHK("lad_idle", 4'h0, ladder_o)
		`CHK("cst_idle", 3'h0, contrast_o)
		wr(6'h0A, 8'hFF, RESP_SLVERR);
		rd(6'h0A, 8'h00, RESP_SLVERR);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence after a ten-cycle reset
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_seg();
		t_pix();
		t_mux();
		t_clk();
		t_lad();
		results();
	end
endmodule
